// File: rtl/rag_pkg.sv
package rag_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 125000000;
    localparam real         ADJ_BLOCK_MS   = 76.3;
    localparam real         BUSY_PERIOD_MS = 190.0;
    // both times round down, never below one cycle
    localparam int unsigned ADJ_BLOCK_CYC  =
        (int'($floor(ADJ_BLOCK_MS * CLK_HZ / 1000.0)) < 1) ? 1 :
        int'($floor(ADJ_BLOCK_MS * CLK_HZ / 1000.0));
    localparam int unsigned BUSY_PERIOD_CYC =
        (int'($floor(BUSY_PERIOD_MS * CLK_HZ / 1000.0)) < 1) ? 1 :
        int'($floor(BUSY_PERIOD_MS * CLK_HZ / 1000.0));

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic ADJ_RESET_VAL   = 1'b0;
    localparam logic BUSY_RESET_VAL  = 1'b0;
    localparam logic CRST_RESET_VAL  = 1'b0;

    // ------------------------------------------------------------
    // adjust sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RAG_ADJ_IDLE  = 2'b00,
        RAG_ADJ_BLOCK = 2'b01,
        RAG_ADJ_HALT  = 2'b11
    } rag_adj_state_t;
endpackage

// File: rtl/rag_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// two flip-flop level synchroniser
// ------------------------------------------------------------
module rag_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// File: rtl/rag_guard.sv
`timescale 1ns/1ps
// Contract
// - writing adjust bit 1 starts adjust, blocks counter access 76.3 ms
// - running oscillator clears adjust bit on its 76.3 ms cycle
// - running oscillator clears busy bit on periodic 190 ms cycle
// - stopped oscillator halts timekeeping and both automatic clears
// - bus select qualifies cycles; standby select qualifies and sets mode
// - standby select going low clears counter reset control bit
module rag_guard
    import rag_pkg::*;
#(
    parameter int unsigned ADJ_CYC  = rag_pkg::ADJ_BLOCK_CYC,
    parameter int unsigned BUSY_CYC = rag_pkg::BUSY_PERIOD_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic bus_chip_select_n,
    input  wire logic standby_chip_select,
    input  wire logic read_strobe_n,
    input  wire logic write_strobe_n,
    input  wire logic osc_running,
    input  wire logic sel_counter,
    input  wire logic sel_adjust,
    input  wire logic sel_reset_ctl,
    input  wire logic wr_data_bit,
    input  wire logic busy_set,
    output logic      thirty_second_adjust,
    output logic      busy,
    output logic      counter_reset_ctl,
    output logic      counter_access_ok,
    output logic      counter_wr_en,
    output logic      counter_rd_en,
    output logic      timekeeping_en,
    output logic      operating_mode
);
    import rag_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [4:0] pins_sync;
    logic       cs_n_s;
    logic       stby_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic       osc_s;

    rag_sync #(.WIDTH(5)) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        // active-low pins enter inverted so reset reads as idle
        .async_in ({~bus_chip_select_n, standby_chip_select,
                    ~read_strobe_n, ~write_strobe_n,
                    osc_running}),
        .sync_out (pins_sync)
    );

    assign cs_n_s = !pins_sync[4];
    assign stby_s = pins_sync[3];
    assign rd_n_s = !pins_sync[2];
    assign wr_n_s = !pins_sync[1];
    assign osc_s  = pins_sync[0];

    // ------------------------------------------------------------
    // cycle qualification
    // ------------------------------------------------------------
    logic wr_n_reg;
    logic wr_edge;
    logic sel_cycle;
    logic wr_cycle;
    logic adj_wr;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_n_reg <= 1'b1;
        end else begin
            wr_n_reg <= wr_n_s;
        end
    end

    assign sel_cycle = !cs_n_s && stby_s;
    assign wr_edge   = wr_n_reg && !wr_n_s;
    assign wr_cycle  = sel_cycle && wr_edge;
    assign adj_wr    = wr_cycle && sel_adjust && wr_data_bit;

    assign operating_mode = stby_s;
    assign timekeeping_en = osc_s && stby_s;

    // ------------------------------------------------------------
    // adjust sequencer
    // ------------------------------------------------------------
    localparam int unsigned AW = $clog2(ADJ_CYC + 1);
    rag_adj_state_t    adj_state_reg;
    rag_adj_state_t    adj_state_next;
    logic [AW-1:0]     adj_cnt_reg;
    logic              adj_done;

    assign adj_done = (adj_cnt_reg == AW'(ADJ_CYC - 1));

    // adjust counter advances only in BLOCK with time running
    function automatic logic adj_counting(input rag_adj_state_t st,
                                          input logic          en);
        return (st == RAG_ADJ_BLOCK) && en;
    endfunction

    always_comb begin
        adj_state_next = adj_state_reg;
        case (adj_state_reg)
            RAG_ADJ_IDLE: begin
                if (adj_wr) begin
                    adj_state_next = RAG_ADJ_BLOCK;
                end
            end
            RAG_ADJ_BLOCK: begin
                if (!timekeeping_en) begin
                    adj_state_next = RAG_ADJ_HALT;
                // a write on the last cycle restarts the block
                end else if (adj_done && !adj_wr) begin
                    adj_state_next = RAG_ADJ_IDLE;
                end
            end
            RAG_ADJ_HALT: begin
                if (timekeeping_en) begin
                    adj_state_next = RAG_ADJ_BLOCK;
                end
            end
            default: adj_state_next = RAG_ADJ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adj_state_reg <= RAG_ADJ_IDLE;
        end else begin
            adj_state_reg <= adj_state_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adj_cnt_reg <= '0;
        end else if (adj_state_reg == RAG_ADJ_IDLE) begin
            adj_cnt_reg <= '0;
        end else if (adj_wr) begin
            adj_cnt_reg <= '0;
        end else if (adj_counting(adj_state_reg, timekeeping_en)) begin
            adj_cnt_reg <= adj_done ? '0 : adj_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            thirty_second_adjust <= ADJ_RESET_VAL;
        end else if (adj_wr) begin
            thirty_second_adjust <= 1'b1;
        end else if (adj_counting(adj_state_reg, timekeeping_en)
                     && adj_done) begin
            thirty_second_adjust <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // busy auto clear
    // ------------------------------------------------------------
    localparam int unsigned BW = $clog2(BUSY_CYC + 1);
    logic [BW-1:0] busy_cnt_reg;
    logic          busy_tick;

    assign busy_tick = timekeeping_en
                       && (busy_cnt_reg == BW'(BUSY_CYC - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= '0;
        end else if (timekeeping_en) begin
            busy_cnt_reg <= busy_tick ? '0 : busy_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= BUSY_RESET_VAL;
        end else if (busy_set && timekeeping_en) begin
            busy <= 1'b1;
        end else if (busy_tick) begin
            busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // counter reset control bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counter_reset_ctl <= CRST_RESET_VAL;
        end else if (!stby_s) begin
            counter_reset_ctl <= 1'b0;
        end else if (wr_cycle && sel_reset_ctl) begin
            counter_reset_ctl <= wr_data_bit;
        end
    end

    // ------------------------------------------------------------
    // counter access gating
    // ------------------------------------------------------------
    assign counter_access_ok = !thirty_second_adjust;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counter_wr_en <= 1'b0;
            counter_rd_en <= 1'b0;
        end else begin
            counter_wr_en <= wr_cycle && sel_counter
                             && !thirty_second_adjust;
            counter_rd_en <= sel_cycle && !rd_n_s && sel_counter
                             && !thirty_second_adjust;
        end
    end
endmodule

// File: dv/rag_assertions.sv
`timescale 1ns/1ps
module rag_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic thirty_second_adjust,
    input wire logic busy,
    input wire logic counter_reset_ctl,
    input wire logic counter_access_ok,
    input wire logic counter_wr_en,
    input wire logic counter_rd_en,
    input wire logic timekeeping_en,
    input wire logic operating_mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    access_gate_a: assert property (
        counter_access_ok == !thirty_second_adjust) else $error("gate");
    wr_gate_a: assert property (
        counter_wr_en |-> !$past(thirty_second_adjust)) else $error("wr");
    rd_gate_a: assert property (
        counter_rd_en |-> !$past(thirty_second_adjust)) else $error("rd");
    standby_ignore_a: assert property (
        !operating_mode |=> !counter_rd_en && !counter_wr_en)
        else $error("standby access");
    adj_hold_a: assert property (
        $rose(thirty_second_adjust) |-> thirty_second_adjust[*8])
        else $error("hold");
    adj_clear_a: assert property (
        $rose(thirty_second_adjust) && timekeeping_en |->
        ##[1:25] (!thirty_second_adjust || !timekeeping_en))
        else $error("adj clr");
    busy_clear_a: assert property (
        $rose(busy) && timekeeping_en |-> ##[1:55] (!busy || !timekeeping_en))
        else $error("busy clr");
    busy_halt_a: assert property (
        !timekeeping_en && busy |=> busy) else $error("busy halt");
    crst_clear_a: assert property (
        !operating_mode[*2] |-> !counter_reset_ctl) else $error("crst");
    standby_frozen_a: assert property (
        !operating_mode |=> $stable(thirty_second_adjust))
        else $error("frozen");
    cover property ($fell(thirty_second_adjust));
    cover property ($fell(busy));
    cover property ($fell(operating_mode));
    cover property (counter_rd_en);
endmodule

// File: dv/rag_host.sv
`timescale 1ns/1ps
module rag_host (
    input  wire logic clk_sys,
    output logic      bus_chip_select_n,
    output logic      standby_chip_select,
    output logic      read_strobe_n,
    output logic      write_strobe_n,
    output logic      sel_counter,
    output logic      sel_adjust,
    output logic      sel_reset_ctl,
    output logic      wr_data_bit
);
    initial begin
        {bus_chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
        {sel_counter, sel_adjust, sel_reset_ctl, wr_data_bit} = 4'h0;
        standby_chip_select = 1'b1;
    end
    // bus write held until well past the sync stages
    task automatic wr(input logic cs_n, input logic [2:0] sel,
                      input logic d);
        @(negedge clk_sys);
        bus_chip_select_n = cs_n;
        {sel_counter, sel_adjust, sel_reset_ctl} = sel;
        wr_data_bit = d;
        write_strobe_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        write_strobe_n = 1'b1;
        bus_chip_select_n = 1'b1;
        {sel_counter, sel_adjust, sel_reset_ctl} = 3'h0;
        wr_data_bit = ~d;
        repeat (3) @(negedge clk_sys);
    endtask
    // counter read held until well past the sync stages
    task automatic rd(input logic cs_n);
        @(negedge clk_sys);
        bus_chip_select_n = cs_n;
        sel_counter = 1'b1;
        read_strobe_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        read_strobe_n = 1'b1;
        bus_chip_select_n = 1'b1;
        sel_counter = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    // strobe idle on both sides of a mode change
    task automatic stby(input logic v);
        repeat (4) @(negedge clk_sys);
        standby_chip_select = v;
        repeat (4) @(negedge clk_sys);
    endtask
endmodule

// File: dv/tb_rtc_adjust_standby_access.sv
`timescale 1ns/1ps
module tb_rtc_adjust_standby_access;
    logic clk_sys, rst_n, osc_running, busy_set, read_strobe_n;
    logic bus_chip_select_n, standby_chip_select, write_strobe_n;
    logic sel_counter, sel_adjust, sel_reset_ctl, wr_data_bit;
    logic thirty_second_adjust, busy, counter_reset_ctl, counter_access_ok;
    logic counter_wr_en, counter_rd_en, timekeeping_en, operating_mode;
    int   errors = 0, tests_run = 0, wr_seen = 0, rd_seen = 0, n;
    rag_guard #(.ADJ_CYC(20), .BUSY_CYC(50)) uut (.clk_sys, .rst_n,
        .bus_chip_select_n, .standby_chip_select, .read_strobe_n,
        .write_strobe_n, .osc_running, .sel_counter, .sel_adjust,
        .sel_reset_ctl, .wr_data_bit, .busy_set, .thirty_second_adjust,
        .busy, .counter_reset_ctl, .counter_access_ok, .counter_wr_en,
        .counter_rd_en, .timekeeping_en, .operating_mode);
    rag_host host (.clk_sys, .bus_chip_select_n, .standby_chip_select,
        .read_strobe_n, .write_strobe_n, .sel_counter, .sel_adjust,
        .sel_reset_ctl, .wr_data_bit);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) if (counter_wr_en === 1'b1) wr_seen++;
    always @(negedge clk_sys) if (counter_rd_en === 1'b1) rd_seen++;
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic poll_adj;
        for (int i = 0; i < 30 && thirty_second_adjust !== 1'b0; i++)
            @(negedge clk_sys);
        chk(thirty_second_adjust, 1'b0);
    endtask
    task automatic pulse_busy;
        @(negedge clk_sys) busy_set = 1'b1;
        @(negedge clk_sys) busy_set = 1'b0;
        chk(busy, 1'b1);
    endtask
    task automatic t_adjust;
        host.wr(1'b1, 3'h2, 1'b1);
        chk(thirty_second_adjust, 1'b0);
        n = rd_seen;
        host.rd(1'b1);
        chk(logic'(rd_seen == n), 1'b1);
        host.wr(1'b0, 3'h2, 1'b1);
        chk(counter_access_ok, 1'b0);
        n = wr_seen;
        host.wr(1'b0, 3'h4, 1'b1);
        chk(logic'(wr_seen == n), 1'b1);
        n = rd_seen;
        host.rd(1'b0);
        chk(logic'(rd_seen == n), 1'b1);
        poll_adj();
        chk(counter_access_ok, 1'b1);
        n = wr_seen;
        host.wr(1'b0, 3'h4, 1'b1);
        chk(logic'(wr_seen == n + 1), 1'b1);
        n = rd_seen;
        host.rd(1'b0);
        chk(logic'(rd_seen > n), 1'b1);
    endtask
    task automatic t_busy;
        pulse_busy();
        repeat (52) @(negedge clk_sys);
        chk(busy, 1'b0);
    endtask
    task automatic t_osc_stop;
        // set held across both sync edges of the stop
        @(negedge clk_sys);
        osc_running = 1'b0;
        busy_set = 1'b1;
        repeat (2) @(negedge clk_sys);
        busy_set = 1'b0;
        chk(busy, 1'b1);
        host.wr(1'b0, 3'h2, 1'b1);
        chk(timekeeping_en, 1'b0);
        repeat (60) @(negedge clk_sys);
        chk(busy, 1'b1);
        chk(thirty_second_adjust, 1'b1);
        osc_running = 1'b1;
        poll_adj();
        repeat (52) @(negedge clk_sys);
        chk(busy, 1'b0);
    endtask
    task automatic t_standby;
        host.wr(1'b0, 3'h1, 1'b1);
        chk(counter_reset_ctl, 1'b1);
        host.stby(1'b0);
        chk(counter_reset_ctl, 1'b0);
        chk(operating_mode, 1'b0);
        host.wr(1'b0, 3'h2, 1'b1);
        chk(thirty_second_adjust, 1'b0);
        n = rd_seen;
        host.rd(1'b0);
        chk(logic'(rd_seen == n), 1'b1);
        host.stby(1'b1);
        chk(operating_mode, 1'b1);
    endtask
    initial begin
        {rst_n, busy_set} = 2'h0;
        osc_running = 1'b1;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_adjust();
        t_busy();
        t_osc_stop();
        t_standby();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        results();
    end
endmodule
bind rag_guard rag_assertions u_chk (.clk_sys, .rst_n,
    .thirty_second_adjust, .busy, .counter_reset_ctl, .counter_access_ok,
    .counter_wr_en, .counter_rd_en, .timekeeping_en, .operating_mode);
